// ### pitu_pkg.sv
// Purpose: constants and types for the prioritized interrupt and trap unit
// Assumes: one clock at 200 MHz, synchronous active-high reset
// Notes: 17 interrupt sources, 8 transfer channels, 16-bit trap flag register
package pitu_pkg;
	localparam int NSRC = 17;
	localparam int NCH = 8;
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_SRC0 = 8'h00;
	localparam logic [7:0] ADDR_CH0 = 8'h20;
	localparam logic [7:0] ADDR_TFR = 8'h40;
	localparam logic [7:0] ADDR_STAT = 8'h41;
	localparam logic [7:0] ADDR_EDGE = 8'h42;
	// Source control register fields
	localparam int B_IR = 7;
	localparam int B_IE = 6;
	localparam int B_XFER = 4;
	// Channel field sits in bits 10:8, clear of the request and enable flags
	localparam int B_CH = 8;
	localparam int F_PRI_W = 4;
	// Channel control register fields
	localparam int B_WORD = 15;
	localparam int B_INCDST = 14;
	localparam int B_CONT = 13;
	localparam int F_CNT_W = 8;
	// Trap flag register bits
	localparam int TF_UNDEF = 15;
	localparam int TF_PROT = 14;
	localparam int TF_ILLOP = 13;
	localparam int TF_FETCH = 12;
	localparam int TF_EXTBUS = 11;
	localparam int TF_NMI = 7;
	localparam int TF_ACCU = 6;
	localparam int TF_OVR = 2;
	localparam int TF_UNR = 1;
	localparam logic [6:0] TRAP_RESET = 7'h00;
	localparam logic [6:0] TRAP_NMI = 7'h02;
	localparam logic [6:0] TRAP_OVR = 7'h04;
	localparam logic [6:0] TRAP_UNR = 7'h06;
	localparam logic [6:0] TRAP_CLASSB = 7'h0a;
	localparam logic [6:0] SRC_TRAP [NSRC] = '{7'h18, 7'h19, 7'h1a, 7'h1b, 7'h22, 7'h23,
		7'h24, 7'h25, 7'h26, 7'h27, 7'h2a, 7'h47, 7'h2b, 7'h2c, 7'h3f, 7'h41, 7'h43};
	localparam int NEXT = 4;
	localparam real CLK_NS = 5.0;
	localparam real LAT_MIN_NS = 100.0;
	localparam real LAT_MAX_NS = 240.0;
	localparam int LAT_MIN_CYC = int'($ceil(LAT_MIN_NS / CLK_NS));
	localparam int LAT_MAX_CYC = int'($floor(LAT_MAX_NS / CLK_NS));
	localparam logic [5:0] LAT_CYC = 6'(LAT_MIN_CYC);
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	typedef struct packed {
		logic valid;
		logic [8:0] vector;
		logic [6:0] trapNum;
		logic [3:0] level;
	} pitu_branch_s;
	typedef struct packed {
		logic valid;
		logic [2:0] chan;
		logic word;
		logic [15:0] srcPtr;
		logic [15:0] dstPtr;
	} pitu_xfer_s;
	typedef enum logic [1:0] {PITU_IDLE, PITU_WAIT, PITU_ISSUE} pitu_state_e;
	function automatic logic [8:0] pituVec(input logic [6:0] num);
		return {num, 2'h0};
	endfunction : pituVec
endpackage : pitu_pkg

// ### pitu_edge_det.sv
// Purpose: selectable edge detector for one fast external input
// Assumes: input synchronous to clk
// Notes: one-cycle pulse per selected edge
`timescale 1ns/1ps
module pitu_edge_det import pitu_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic pinIn,
	input wire logic [1:0] mode,
	output logic pulse
);
	logic prev_q;
	wire logic rise = pinIn & ~prev_q;
	wire logic fall = ~pinIn & prev_q;
	assign pulse = (rise & mode[0]) | (fall & mode[1]);
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= pinIn;
		end
	end
	edge_sel_a: assert property (@(posedge clk) disable iff (rst)
		pulse |-> (rise || fall) && ((mode == EDGE_BOTH) || (mode == EDGE_RISE && rise) ||
		(mode == EDGE_FALL && fall))) else $error("edge pulse without selected edge");
endmodule : pitu_edge_det

// ### pitu_top.sv
// Purpose: arbitration of interrupts, event transfers and hardware traps
// Assumes: CPU takes branch when brAck high; transfer done in one stolen cycle
// Notes: request latency padded to stay inside the 100..240 ns window
`timescale 1ns/1ps
module pitu_top import pitu_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire logic [NSRC-1:0] periphReq,
	input wire logic [NEXT-1:0] extPin,
	input wire logic nmiReq,
	input wire logic stackOverrun,
	input wire logic stackUnderrun,
	input wire logic [4:0] classBReq,
	input wire logic accuTrapReq,
	input wire logic swTrap,
	input wire logic [6:0] swTrapNum,
	input wire logic [3:0] cpuLevel,
	input wire logic resetReq,
	input wire logic serviceEnd,
	input wire logic brAck,
	output pitu_branch_s branch,
	output pitu_xfer_s xfer
);
	// ****************************************
	// Registers
	// ****************************************
	logic [15:0] srcCtl_q [NSRC];
	logic [15:0] chCtl_q [NCH];
	logic [15:0] chSrc_q [NCH];
	logic [15:0] chDst_q [NCH];
	logic [15:0] trapFlags_q;
	logic [2*NEXT-1:0] edgeMode_q;
	logic [3:0] curLevel_q;
	logic inTrap_q;
	logic [1:0] trapPri_q;
	pitu_state_e state_q;
	logic [5:0] lat_q;
	logic [4:0] pend_q;
	logic pendTrap_q;
	logic pendXfer_q;
	logic [15:0] rdata_q;
	pitu_branch_s branch_q;
	pitu_xfer_s xfer_q;
	// ****************************************
	// Source request collection
	// ****************************************
	logic [NEXT-1:0] extPulse;
	genvar gi;
	generate
		for (gi = 0; gi < NEXT; gi++) begin : g_ext
			pitu_edge_det u_edge (
				.clk(clk),
				.rst(rst),
				.pinIn(extPin[gi]),
				.mode(edgeMode_q[2*gi+1:2*gi]),
				.pulse(extPulse[gi])
			);
		end
	endgenerate
	wire logic [NSRC-1:0] hwEvent = periphReq | {{(NSRC-NEXT){1'b0}}, extPulse};
	// ****************************************
	// Arbitration
	// ****************************************
	logic [NSRC-1:0] active;
	logic [4:0] winIdx;
	logic [3:0] winLvl;
	logic winAny;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_act
			assign active[gi] = srcCtl_q[gi][B_IR] & srcCtl_q[gi][B_IE];
		end
	endgenerate
	// highest level wins, lowest index on ties
	always_comb begin
		winIdx = 5'h0;
		winLvl = 4'h0;
		winAny = 1'b0;
		for (int i = 0; i < NSRC; i++) begin
			if (active[i] && (!winAny || srcCtl_q[i][F_PRI_W-1:0] > winLvl)) begin
				winAny = 1'b1;
				winIdx = 5'(i);
				winLvl = srcCtl_q[i][F_PRI_W-1:0];
			end
		end
	end
	wire logic [2:0] winCh = srcCtl_q[winIdx][B_CH+2:B_CH];
	wire logic winXfer = srcCtl_q[winIdx][B_XFER];
	wire logic [F_CNT_W-1:0] winCnt = chCtl_q[winCh][F_CNT_W-1:0];
	// strictly higher only; traps block normal requests
	wire logic canPreempt = winAny && winLvl > curLevel_q && !inTrap_q && state_q == PITU_IDLE;
	// counter zero turns the request into a normal interrupt
	wire logic doXfer = winXfer && winCnt != '0;
	// Trap priority: reset 3, class A 2, class B 1
	wire logic trapA = nmiReq | stackOverrun | stackUnderrun;
	wire logic trapB = |classBReq | accuTrapReq;
	wire logic [1:0] newTrapPri = resetReq ? 2'h3 : trapA ? 2'h2 : trapB ? 2'h1 : 2'h0;
	// trap preempts unless an equal or higher trap runs
	wire logic trapGo = newTrapPri != 2'h0 && (!inTrap_q || newTrapPri > trapPri_q);
	wire logic [6:0] trapNum = resetReq ? TRAP_RESET : nmiReq ? TRAP_NMI :
		stackOverrun ? TRAP_OVR : stackUnderrun ? TRAP_UNR : TRAP_CLASSB;
	// ****************************************
	// Register bus
	// ****************************************
	wire logic srcHit = regAddr < ADDR_W'(NSRC);
	wire logic [4:0] srcSel = regAddr[4:0];
	wire logic chHit = regAddr >= ADDR_CH0 && regAddr < ADDR_CH0 + ADDR_W'(3 * NCH);
	wire logic [4:0] chOff = 5'(regAddr - ADDR_CH0);
	wire logic [2:0] chSel = 3'(chOff / 5'h3);
	wire logic [1:0] chKind = 2'(chOff % 5'h3);
	logic [15:0] rdMux;
	always_comb begin
		rdMux = 16'h0;
		if (srcHit) begin
			rdMux = srcCtl_q[srcSel];
		end else if (chHit) begin
			rdMux = chKind == 2'h0 ? chCtl_q[chSel] : chKind == 2'h1 ? chSrc_q[chSel] :
				chDst_q[chSel];
		end else if (regAddr == ADDR_TFR) begin
			rdMux = trapFlags_q;
		end else if (regAddr == ADDR_STAT) begin
			rdMux = {10'h0, trapPri_q, curLevel_q};
		end else if (regAddr == ADDR_EDGE) begin
			rdMux = {8'h0, edgeMode_q};
		end
	end
	// ****************************************
	// Source control registers
	// ****************************************
	wire logic issue = state_q == PITU_ISSUE;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_src
			wire logic wrHit = regWr && srcHit && srcSel == 5'(gi);
			wire logic served = issue && !pendTrap_q && pend_q == 5'(gi) && pendXfer_q;
			always_ff @(posedge clk) begin
				if (rst) begin
					srcCtl_q[gi] <= 16'h0;
				end else begin
					if (wrHit) begin
						srcCtl_q[gi] <= regWdata;
					end
					// Transfer service clears its own request; set still wins
					if (served) begin
						srcCtl_q[gi][B_IR] <= 1'b0;
					end
					// hardware set wins over a software clear
					if (hwEvent[gi]) begin
						srcCtl_q[gi][B_IR] <= 1'b1;
					end
				end
			end
		end
	endgenerate
	// ****************************************
	// Trap flag register
	// ****************************************
	wire logic [15:0] trapSet = {classBReq, 3'h0, nmiReq, accuTrapReq, 3'h0,
		stackOverrun, stackUnderrun, 1'b0};
	always_ff @(posedge clk) begin
		if (rst) begin
			trapFlags_q <= 16'h0;
			edgeMode_q <= {NEXT{EDGE_RISE}};
		end else begin
			if (regWr && regAddr == ADDR_EDGE) begin
				edgeMode_q <= regWdata[2*NEXT-1:0];
			end
			// per-trap flag bit; accumulator on bit 6
			trapFlags_q <= ((regWr && regAddr == ADDR_TFR) ? regWdata : trapFlags_q) | trapSet;
		end
	end
	// ****************************************
	// Transfer channels
	// ****************************************
	wire logic xferFire = issue && pendXfer_q && !pendTrap_q;
	wire logic [2:0] fireCh = srcCtl_q[pend_q][B_CH+2:B_CH];
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			wire logic mine = xferFire && fireCh == 3'(gi);
			wire logic [15:0] step = chCtl_q[gi][B_WORD] ? 16'h2 : 16'h1;
			always_ff @(posedge clk) begin
				if (rst) begin
					chCtl_q[gi] <= 16'h0;
					chSrc_q[gi] <= 16'h0;
					chDst_q[gi] <= 16'h0;
				end else if (regWr && chHit && chSel == 3'(gi)) begin
					if (chKind == 2'h0) chCtl_q[gi] <= regWdata;
					if (chKind == 2'h1) chSrc_q[gi] <= regWdata;
					if (chKind == 2'h2) chDst_q[gi] <= regWdata;
				end else if (mine) begin
					if (chCtl_q[gi][B_INCDST]) chDst_q[gi] <= chDst_q[gi] + step;
					else chSrc_q[gi] <= chSrc_q[gi] + step;
					if (!chCtl_q[gi][B_CONT]) begin
						chCtl_q[gi][F_CNT_W-1:0] <= chCtl_q[gi][F_CNT_W-1:0] - 1'b1;
					end
				end
			end
		end
	endgenerate
	// ****************************************
	// Service sequencer
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= PITU_IDLE;
			lat_q <= 6'h0;
			pend_q <= 5'h0;
			pendTrap_q <= 1'b0;
			pendXfer_q <= 1'b0;
			curLevel_q <= 4'h0;
			inTrap_q <= 1'b0;
			trapPri_q <= 2'h0;
			branch_q <= '0;
			xfer_q <= '0;
			rdata_q <= 16'h0;
		end else begin
			rdata_q <= regRd ? rdMux : rdata_q;
			xfer_q.valid <= 1'b0;
			if (serviceEnd) begin
				inTrap_q <= 1'b0;
				trapPri_q <= 2'h0;
				curLevel_q <= cpuLevel;
			end
			if (branch_q.valid && brAck) begin
				branch_q.valid <= 1'b0;
			end
			case (state_q)
				PITU_IDLE: begin
					if (trapGo) begin
						pendTrap_q <= 1'b1;
						trapPri_q <= newTrapPri;
						inTrap_q <= 1'b1;
						lat_q <= LAT_CYC;
						state_q <= PITU_WAIT;
						branch_q.trapNum <= trapNum;
					end else if (swTrap) begin
						branch_q <= '{1'b1, pituVec(swTrapNum), swTrapNum, cpuLevel};
					end else if (canPreempt) begin
						// source selects transfer or vectored service
						pendTrap_q <= 1'b0;
						pend_q <= winIdx;
						pendXfer_q <= doXfer;
						lat_q <= LAT_CYC;
						state_q <= PITU_WAIT;
					end
				end
				PITU_WAIT: begin
					lat_q <= lat_q - 6'h1;
					if (lat_q == 6'h1) state_q <= PITU_ISSUE;
				end
				PITU_ISSUE: begin
					state_q <= PITU_IDLE;
					if (pendTrap_q) begin
						branch_q <= '{1'b1, pituVec(branch_q.trapNum), branch_q.trapNum, 4'hf};
					end else if (pendXfer_q) begin
						xfer_q <= '{1'b1, fireCh, chCtl_q[fireCh][B_WORD],
							chSrc_q[fireCh], chDst_q[fireCh]};
					end else begin
						// branch to the source's own vector
						branch_q <= '{1'b1, pituVec(SRC_TRAP[pend_q]), SRC_TRAP[pend_q],
							srcCtl_q[pend_q][F_PRI_W-1:0]};
						curLevel_q <= srcCtl_q[pend_q][F_PRI_W-1:0];
					end
				end
				default: state_q <= PITU_IDLE;
			endcase
		end
	end
	assign regRdata = rdata_q;
	assign branch = branch_q;
	assign xfer = xfer_q;
	// ****************************************
	// Checks
	// ****************************************
	// Latency is a fixed pad, so the check pins it to one exact cycle count
	latency_window_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == PITU_IDLE && $past(state_q) == PITU_ISSUE) |->
		$past(state_q, LAT_MIN_CYC + 2) == PITU_IDLE) else $error("service latency off");
	xfer_one_a: assert property (@(posedge clk) disable iff (rst)
		xfer.valid |=> !xfer.valid) else $error("transfer longer than one cycle");
	xfer_nobr_a: assert property (@(posedge clk) disable iff (rst)
		$rose(xfer.valid) |-> !$rose(branch.valid)) else $error("transfer branched");
	trap_flag_a: assert property (@(posedge clk) disable iff (rst)
		accuTrapReq |=> trapFlags_q[TF_ACCU]) else $error("accumulator flag missing");
	nmi_flag_a: assert property (@(posedge clk) disable iff (rst)
		nmiReq |=> trapFlags_q[TF_NMI]) else $error("nonmaskable flag missing");
	vec_times4_a: assert property (@(posedge clk) disable iff (rst)
		branch.valid |-> branch.vector == {branch.trapNum, 2'h0})
		else $error("vector not four times number");
	reset_vec_a: assert property (@(posedge clk) disable iff (rst)
		(branch.valid && branch.trapNum == TRAP_RESET && pendTrap_q) |-> branch.vector == 9'h0)
		else $error("reset vector wrong");
	trap_take_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == PITU_IDLE && trapGo) |=> inTrap_q) else $error("trap not taken");
	trapb_num_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == PITU_IDLE && trapGo && newTrapPri == 2'h1) |=>
		branch_q.trapNum == TRAP_CLASSB) else $error("class b trap number wrong");
	// Views of the firing channel and pending source for the checks below
	wire logic [F_CNT_W-1:0] fireCnt = chCtl_q[fireCh][F_CNT_W-1:0];
	wire logic [F_PRI_W-1:0] pendLvl = srcCtl_q[pend_q][F_PRI_W-1:0];
	cnt_dec_a: assert property (@(posedge clk) disable iff (rst)
		(xferFire && !chCtl_q[fireCh][B_CONT] && !regWr) |=>
		chCtl_q[$past(fireCh)][F_CNT_W-1:0] == $past(fireCnt) - 1'b1)
		else $error("count not decremented");
	cont_hold_a: assert property (@(posedge clk) disable iff (rst)
		(xferFire && chCtl_q[fireCh][B_CONT] && !regWr) |=>
		chCtl_q[$past(fireCh)][F_CNT_W-1:0] == $past(fireCnt))
		else $error("continuous count moved");
	preempt_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == PITU_IDLE && !trapGo && !swTrap && winAny && winLvl <= curLevel_q)
		|=> state_q == PITU_IDLE) else $error("equal level preempted");
	// A trap in service shuts out normal and transfer requests entirely
	trap_block_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == PITU_IDLE && inTrap_q) |=> !(state_q == PITU_WAIT && !pendTrap_q))
		else $error("normal request entered a trap service");
	trap_pre_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == PITU_IDLE && inTrap_q && newTrapPri > trapPri_q) |=>
		(state_q == PITU_WAIT && pendTrap_q)) else $error("higher trap not taken");
	zero_cnt_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == PITU_IDLE && !trapGo && !swTrap && canPreempt && winXfer && winCnt == '0)
		|=> (state_q == PITU_WAIT && !pendXfer_q)) else $error("empty channel still moved");
	issue_branch_a: assert property (@(posedge clk) disable iff (rst)
		(issue && !pendTrap_q && !pendXfer_q) |=>
		(branch.valid && branch.level == $past(pendLvl)))
		else $error("normal service did not branch");
	swtrap_lvl_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == PITU_IDLE && !trapGo && swTrap) |=> (branch.valid &&
		branch.level == $past(cpuLevel) && branch.trapNum == $past(swTrapNum)))
		else $error("software trap level or number wrong");
	// Main scenarios
	cov_xfer_c: cover property (@(posedge clk) xfer.valid);
	cov_trap_c: cover property (@(posedge clk) branch.valid && pendTrap_q);
	cov_irq_c: cover property (@(posedge clk) branch.valid && !pendTrap_q);
	cov_soft_c: cover property (@(posedge clk) state_q == PITU_IDLE && !trapGo && swTrap);
	cov_nest_c: cover property (@(posedge clk) canPreempt && curLevel_q != 4'h0);
endmodule : pitu_top

// ### pitu_cpu_model.sv
// Purpose: behavioural CPU core that takes branches and ends services
// Assumes: branch stays valid until acknowledged
// Notes: slow makes the ack wait four extra cycles
`timescale 1ns/1ps
module pitu_cpu_model import pitu_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input pitu_branch_s branch,
	input wire logic slow,
	input wire logic endReq,
	output logic brAck,
	output logic serviceEnd,
	output logic [3:0] cpuLevel
);
	logic [3:0] stack_q [4];
	logic [1:0] depth_q;
	logic busy_q;
	logic [2:0] wait_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			brAck <= 1'b0;
			serviceEnd <= 1'b0;
			cpuLevel <= 4'h0;
			depth_q <= 2'h0;
			busy_q <= 1'b0;
			wait_q <= 3'h0;
		end else begin
			brAck <= 1'b0;
			serviceEnd <= endReq;
			if (branch.valid !== 1'b1) begin
				busy_q <= 1'b0;
				wait_q <= 3'h0;
			end else if (!busy_q) begin
				if (!slow || wait_q == 3'h4) begin
					brAck <= 1'b1;
					busy_q <= 1'b1;
					stack_q[depth_q] <= cpuLevel;
					depth_q <= depth_q + 2'h1;
					cpuLevel <= branch.level;
				end else begin
					wait_q <= wait_q + 3'h1;
				end
			end
			if (endReq) begin
				depth_q <= depth_q - 2'h1;
				cpuLevel <= stack_q[depth_q - 2'h1];
			end
		end
	end
endmodule : pitu_cpu_model

// ### tb_pitu_top.sv
// Purpose: self-checking bench for the interrupt and trap unit
// Assumes: cpu model acks branches, bench ends services
// Notes: bench clears request and trap flags before each service end, except the nested NMI end in the trap test
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_pitu_top import pitu_pkg::*; ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [15:0] regWdata = '0;
	logic [15:0] regRdata;
	logic regWr = 1'b0, regRd = 1'b0, nmiReq = 1'b0, stackOverrun = 1'b0;
	logic stackUnderrun = 1'b0, accuTrapReq = 1'b0, swTrap = 1'b0, resetReq = 1'b0;
	logic slow = 1'b0, endReq = 1'b0, brAck, serviceEnd;
	logic [NSRC-1:0] periphReq = '0;
	logic [NEXT-1:0] extPin = '0;
	logic [4:0] classBReq = '0;
	logic [6:0] swTrapNum = '0;
	logic [3:0] cpuLevel;
	pitu_branch_s branch;
	pitu_xfer_s xfer;
	int fails = 0, cmp_count = 0, lat;
	logic [15:0] rv;
	always #2.5 clk = ~clk;
	pitu_top dut (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .periphReq,
		.extPin, .nmiReq, .stackOverrun, .stackUnderrun, .classBReq, .accuTrapReq, .swTrap,
		.swTrapNum, .cpuLevel, .resetReq, .serviceEnd, .brAck, .branch, .xfer);
	pitu_cpu_model cpu (.clk, .rst, .branch, .slow, .endReq, .brAck, .serviceEnd, .cpuLevel);
	// ****************
	// Bus and service helpers
	// ****************
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 rv = regRdata;
	endtask : rd
	task automatic pulse(input logic [NSRC-1:0] m, input int k);
		@(posedge clk);
		periphReq <= m;
		{nmiReq, stackOverrun, stackUnderrun} <= {k == 1, k == 2, k == 3};
		classBReq <= (k >= 4 && k < 9) ? 5'(1 << (k - 4)) : 5'h00;
		{accuTrapReq, resetReq, swTrap} <= {k == 9, k == 10, k == 11};
		@(posedge clk);
		periphReq <= '0;
		classBReq <= '0;
		{nmiReq, stackOverrun, stackUnderrun, accuTrapReq, resetReq, swTrap} <= '0;
	endtask : pulse
	task automatic waitSvc();
		lat = 0;
		while (branch.valid !== 1'b1 && xfer.valid !== 1'b1 && lat < 100) begin
			@(posedge clk);
			#1 lat++;
		end
		`CHK(lat < 100, 1'b1)
	endtask : waitSvc
	task automatic endSvc();
		repeat (8) @(posedge clk);
		endReq <= 1'b1;
		@(posedge clk);
		endReq <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : endSvc
	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge clk);
			#1 seen = seen | branch.valid | xfer.valid;
		end
		`CHK(seen, 1'b0)
	endtask : quiet
	// ****************
	// Scenarios
	// ****************
	task automatic t_regs();
		rd(ADDR_TFR);
		`CHK(rv, 16'h0000)
		rd(8'hff);
		`CHK(rv, 16'h0000)
		wr(ADDR_SRC0 + 8'd14, 16'h0045);
		rd(ADDR_SRC0 + 8'd14);
		`CHK(rv, 16'h0045)
		$display("test regs done");
	endtask : t_regs
	task automatic t_irq();
		pulse(17'h04000, 0);
		waitSvc();
		`CHK(lat * 5 >= 100 && lat * 5 <= 240, 1'b1)
		`CHK(branch.vector, 9'h0fc)
		`CHK({branch.valid, branch.trapNum}, 8'hbf)
		`CHK(branch.level, 4'h5)
		wr(ADDR_SRC0 + 8'd14, 16'h0045);
		endSvc();
		$display("test irq done");
	endtask : t_irq
	task automatic t_prio();
		@(posedge clk) slow <= 1'b1;
		wr(ADDR_SRC0 + 8'd3, 16'h0043);
		wr(ADDR_SRC0, 16'h0047);
		wr(ADDR_SRC0 + 8'd1, 16'h0047);
		wr(ADDR_SRC0 + 8'd2, 16'h0049);
		pulse(17'h00009, 0);
		waitSvc();
		`CHK({branch.vector, branch.level}, 13'h0607)
		repeat (8) @(posedge clk);
		pulse(17'h00002, 0);
		quiet(40);
		pulse(17'h00004, 0);
		waitSvc();
		`CHK({branch.vector, branch.level}, 13'h0689)
		for (int s = 0; s < 4; s++) wr(ADDR_SRC0 + 8'(s), 16'h0000);
		endSvc();
		endSvc();
		slow <= 1'b0;
		$display("test prio done");
	endtask : t_prio
	task automatic t_edge();
		for (int m = 1; m < 4; m++) begin
			wr(ADDR_EDGE, 16'(m << 2));
			@(posedge clk) extPin[1] <= 1'b1;
			repeat (4) @(posedge clk);
			rd(ADDR_SRC0 + 8'd1);
			`CHK(rv[B_IR], 1'(m & 1))
			wr(ADDR_SRC0 + 8'd1, 16'h0000);
			@(posedge clk) extPin[1] <= 1'b0;
			repeat (4) @(posedge clk);
			rd(ADDR_SRC0 + 8'd1);
			`CHK(rv[B_IR], 1'(m >> 1))
			wr(ADDR_SRC0 + 8'd1, 16'h0000);
		end
		$display("test edge done");
	endtask : t_edge
	task automatic t_traps();
		logic [8:0] vec [9] = '{9'h008, 9'h010, 9'h018, 9'h028, 9'h028, 9'h028, 9'h028,
			9'h028, 9'h028};
		int bitn [9] = '{TF_NMI, TF_OVR, TF_UNR, TF_EXTBUS, TF_FETCH, TF_ILLOP, TF_PROT,
			TF_UNDEF, TF_ACCU};
		for (int k = 0; k < 9; k++) begin
			pulse('0, k + 1);
			waitSvc();
			`CHK(branch.vector, vec[k])
			`CHK({branch.trapNum, branch.level}, {vec[k][8:2], 4'hf})
			rd(ADDR_TFR);
			`CHK(rv, 16'(1 << bitn[k]))
			if (k == 0) begin
				wr(ADDR_SRC0 + 8'd14, 16'h00cf);
				quiet(40);
				wr(ADDR_SRC0 + 8'd14, 16'h0000);
			end
			if (k == 8) begin
				pulse('0, 1);
				waitSvc();
				`CHK(branch.vector, 9'h008)
				endSvc();
			end
			wr(ADDR_TFR, 16'h0000);
			endSvc();
		end
		$display("test traps done");
	endtask : t_traps
	task automatic t_xfer();
		wr(ADDR_CH0 + 8'd6, 16'h8002);
		wr(ADDR_CH0 + 8'd7, 16'h1000);
		wr(ADDR_CH0 + 8'd8, 16'h2000);
		wr(ADDR_SRC0 + 8'd13, 16'h0254);
		for (int n = 0; n < 3; n++) begin
			pulse(17'h02000, 0);
			waitSvc();
			if (n < 2) begin
				`CHK({xfer.valid, xfer.chan, xfer.word}, 5'h15)
				`CHK({xfer.srcPtr == 16'h1000, xfer.dstPtr}, {1'(n == 0), 16'h2000})
				@(posedge clk);
				#1 `CHK({xfer.valid, branch.valid}, 2'b00)
				rd(ADDR_CH0 + 8'd6);
				`CHK(rv[7:0], 8'(1 - n))
			end else begin
				`CHK({branch.valid, branch.vector}, 10'h2b0)
			end
		end
		wr(ADDR_SRC0 + 8'd13, 16'h0000);
		endSvc();
		wr(ADDR_CH0 + 8'd6, 16'h6005);
		wr(ADDR_SRC0 + 8'd13, 16'h0254);
		pulse(17'h02000, 0);
		waitSvc();
		`CHK({xfer.valid, xfer.word}, 2'b10)
		rd(ADDR_CH0 + 8'd6);
		`CHK(rv[7:0], 8'h05)
		rd(ADDR_CH0 + 8'd8);
		`CHK(rv, 16'h2001)
		wr(ADDR_SRC0 + 8'd13, 16'h0000);
		$display("test xfer done");
	endtask : t_xfer
	task automatic t_soft();
		@(posedge clk) swTrapNum <= 7'h7f;
		pulse('0, 11);
		waitSvc();
		`CHK({branch.vector, branch.level}, 13'h1fc0)
		endSvc();
		pulse('0, 10);
		waitSvc();
		`CHK({branch.valid, branch.vector, branch.trapNum}, 17'h10000)
		endSvc();
		$display("test soft done");
	endtask : t_soft
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_irq();
		t_prio();
		t_edge();
		t_traps();
		t_xfer();
		t_soft();
		tally_and_finish();
	end
	// Whole run needs under a thousand cycles; this cuts a hang short
	initial begin
		#200000;
		fails++;
		tally_and_finish();
	end
endmodule : tb_pitu_top
